// File: verilog/eisn_pkg.sv
// Constants, encodings and register map of the external pin interrupt sense block
package eisn_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte addresses on the AHB-Lite bus
    localparam logic [7:0] ADDR_SENSE = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_PSW = 8'h10;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int SENSE_A_LO = 0;
    localparam int SENSE_A_HI = 1;
    localparam int SENSE_B_LO = 2;
    localparam int SENSE_B_HI = 3;
    localparam int SENSE_C_EDGE = 6;
    localparam int EN_A = 6;
    localparam int EN_B = 7;
    localparam int EN_C = 5;
    localparam int FLAG_A = 6;
    localparam int FLAG_B = 7;
    localparam int FLAG_C = 5;
    localparam int PSW_GIE = 7;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and writable masks
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic [7:0] MASK_SENSE = 8'h0f;
    localparam logic [7:0] MASK_STATUS = 8'h40;
    localparam logic [7:0] MASK_CTRL = 8'he0;
    localparam logic [7:0] MASK_PSW = 8'h80;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int WDT_PERIOD_NS = 1000;
    localparam int WDT_TICK_CYCLES = WDT_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0] WDT_TICK_LAST = 8'(WDT_TICK_CYCLES - 1);
    localparam int STARTUP_DEFAULT = 1024;

    ////////////////////////////////////////////////////////////////////////////////
    // Encodings
    typedef enum logic [1:0]
    {
        EISN_LOW = 2'b00,
        EISN_ANY = 2'b01,
        EISN_FALL = 2'b10,
        EISN_RISE = 2'b11
    } eisn_sense_e;

    typedef enum logic [1:0]
    {
        EISN_W_IDLE = 2'b00,
        EISN_W_ONE = 2'b01,
        EISN_W_START = 2'b10
    } eisn_wake_e;

endpackage : eisn_pkg

// File: verilog/eisn_pin_sync.sv
// Two-stage pin synchroniser followed by a previous-value register
module eisn_pin_sync
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic pin_in,
    output logic lvl_out,
    output logic prev_out
);

    logic meta;

    // Meta is read only by lvl_out
    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            meta <= 1'b1;
            lvl_out <= 1'b1;
            prev_out <= 1'b1;
        end
        else
        begin
            meta <= pin_in;
            lvl_out <= meta; // R20
            prev_out <= lvl_out; // R20
        end
    end

endmodule : eisn_pin_sync

// File: verilog/eisn_wake_sampler.sv
// Power-down wake sampler for a level-sensed pin: two ticks, then start-up wait
module eisn_wake_sampler
    import eisn_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_DEFAULT
)
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic tick_in,
    input wire logic arm_in,
    input wire logic low_in,
    output logic wake_out,
    output logic busy_out
);

    eisn_wake_e state;
    eisn_wake_e next_state;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic next_wake;

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_wake = 1'b0;
        case (state)
            EISN_W_IDLE:
            begin
                if (arm_in && tick_in && low_in)
                begin
                    next_state = EISN_W_ONE;
                end
            end
            EISN_W_ONE:
            begin
                // Second watchdog sample decides; a lost level means noise
                if (!arm_in || (tick_in && !low_in))
                begin
                    next_state = EISN_W_IDLE;
                end
                else if (tick_in)
                begin
                    next_state = EISN_W_START; // R06
                    next_wake = 1'b1; // R06
                    next_cnt = 16'(STARTUP_CYCLES - 1);
                end
            end
            EISN_W_START:
            begin
                // Wake stands even if the level vanishes; the request is
                // only raised by the caller if the pin is still low after
                if (cnt == 16'h0000)
                begin
                    next_state = EISN_W_IDLE; // R07
                end
                else
                begin
                    next_cnt = cnt - 16'h0001;
                end
            end
            default:
            begin
                next_state = EISN_W_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            state <= EISN_W_IDLE;
            cnt <= 16'h0000;
            wake_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            wake_out <= next_wake;
        end
    end

    assign busy_out = (state == EISN_W_START);

endmodule : eisn_wake_sampler

// File: verilog/eisn_top.sv
// External pin interrupt sense block with AHB-Lite register slave
//
// Notes on behaviour
// R01: Pins trigger even when configured as outputs.
// R02: Pin c edge only; a, b level or edge.
// R03: Level mode requests while pin stays low.
// R04: Pin a, b edges need running I/O clock.
// R05: Level and pin c edge work without I/O clock.
// R06: Power-down level wake sampled twice, 1 us ticks.
// R07: Level gone after start-up: wake, no request.
// R08: Pin b sense field bits 3:2, four encodings.
// R09: Pin a sense field bits 1:0, same encodings.
// R10: Sample pins before edge detection; long pulses caught.
// R11: Source holds level until instruction completes.
// R12: Request needs global and per-pin enable.
// R13: Status bit 6 picks pin c falling or rising.
// R14: Pin c edges of 50 ns caught.
// R15: Changing pin c sense may raise spurious request.
// R16: Software disables, changes sense, clears, re-enables.
// R17: Flags set by events, cleared by ack or one.
// R18: Level-mode flags of pins a, b read zero.
// R19: Enables a, b, c at bits 6, 7, 5.
// R20: Synchroniser then previous-value compare for edges.
module eisn_top
    import eisn_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_DEFAULT
)
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic ext_irq_pin_a_in,
    input wire logic ext_irq_pin_b_in,
    input wire logic ext_irq_pin_c_in,
    input wire logic io_clk_run_in,
    input wire logic power_down_in,
    input wire logic [2:0] irq_ack_in,
    output logic [2:0] irq_req_out,
    output logic wake_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and state

    logic [7:0] cpu_control_sense;
    logic [7:0] cpu_control_status;
    logic [7:0] general_irq_control;
    logic [7:0] processor_status_word;
    logic [2:0] flag;
    logic [2:0] next_flag;
    logic dp_wr;
    logic dp_rd;
    logic [7:0] dp_addr;
    logic sense_c_q;
    logic [7:0] tick_cnt;
    logic tick;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; pin direction is never consulted, so an output pin
    // still reaches the detectors

    logic [2:0] pin_raw;
    logic [2:0] pin_lvl;
    logic [2:0] pin_prev;

    assign pin_raw = {ext_irq_pin_c_in, ext_irq_pin_b_in, ext_irq_pin_a_in}; // R01

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            eisn_pin_sync u_sync
            (
                .ref_clk_in(ref_clk_in),
                .rstn_in(rstn_in),
                .pin_in(pin_raw[gi]),
                .lvl_out(pin_lvl[gi]),
                .prev_out(pin_prev[gi])
            ); // R10
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog-rate tick, one cycle in every WDT_TICK_CYCLES

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            tick_cnt <= 8'h00;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (tick_cnt == WDT_TICK_LAST); // R06
            tick_cnt <= (tick_cnt == WDT_TICK_LAST) ? 8'h00 : tick_cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Enables and sense selection

    wire gie = processor_status_word[PSW_GIE];
    wire [2:0] pin_en = {general_irq_control[EN_C], general_irq_control[EN_B],
        general_irq_control[EN_A]}; // R19
    wire sense_c = cpu_control_status[SENSE_C_EDGE]; // R13

    eisn_sense_e mode [2];
    assign mode[0] = eisn_sense_e'({cpu_control_sense[SENSE_A_HI],
        cpu_control_sense[SENSE_A_LO]}); // R09
    assign mode[1] = eisn_sense_e'({cpu_control_sense[SENSE_B_HI],
        cpu_control_sense[SENSE_B_LO]}); // R08

    ////////////////////////////////////////////////////////////////////////////////
    // Pins a and b: clocked edge detect, asynchronous-style level path

    logic [1:0] is_level;
    logic [1:0] edge_hit;
    logic [1:0] level_req;
    logic [1:0] wake_ab;
    logic [1:0] wake_busy;

    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_ab
            wire chg = pin_lvl[gi] ^ pin_prev[gi]; // R20
            wire fall = pin_prev[gi] & ~pin_lvl[gi];
            wire rise = ~pin_prev[gi] & pin_lvl[gi];
            wire any_hit = (mode[gi] == EISN_ANY) & chg;
            wire fall_hit = (mode[gi] == EISN_FALL) & fall;
            wire rise_hit = (mode[gi] == EISN_RISE) & rise;

            assign is_level[gi] = (mode[gi] == EISN_LOW); // R02
            // Without the I/O clock the edge logic sees nothing
            assign edge_hit[gi] = io_clk_run_in & (any_hit | fall_hit | rise_hit); // R04 R10
            // Held off in power-down and during start-up so a level that
            // vanishes before start-up ends raises no request
            assign level_req[gi] = is_level[gi] & ~pin_lvl[gi] & ~power_down_in
                & ~wake_busy[gi]; // R03 R05 R07

            eisn_wake_sampler #(
                .STARTUP_CYCLES(STARTUP_CYCLES)
            ) u_wake
            (
                .ref_clk_in(ref_clk_in),
                .rstn_in(rstn_in),
                .tick_in(tick),
                .arm_in(power_down_in & is_level[gi] & pin_en[gi]),
                .low_in(~pin_lvl[gi]),
                .wake_out(wake_ab[gi]),
                .busy_out(wake_busy[gi])
            ); // R05 R06
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Pin c: edge only, works with the I/O clock stopped. Polarity uses the
    // previous sense value, so a sense change alone can look like an edge.

    wire c_pol_now = pin_lvl[2] ^ sense_c;
    wire c_pol_prev = pin_prev[2] ^ sense_c_q;
    wire c_hit = c_pol_prev & ~c_pol_now; // R02 R05 R14 R15

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave decode

    wire ahb_go = hsel_in & htrans_in[1] & hready_in;
    wire wr_sense = dp_wr & (dp_addr == ADDR_SENSE);
    wire wr_status = dp_wr & (dp_addr == ADDR_STATUS);
    wire wr_ctrl = dp_wr & (dp_addr == ADDR_CTRL);
    wire wr_flags = dp_wr & (dp_addr == ADDR_FLAGS);
    wire wr_psw = dp_wr & (dp_addr == ADDR_PSW);
    wire [7:0] wdat = hwdata_in[7:0];

    wire [7:0] flag_view = {flag[1], flag[0], flag[2], 5'h00};
    wire [7:0] rd_byte;
    assign rd_byte = (dp_addr == ADDR_SENSE) ? cpu_control_sense
        : (dp_addr == ADDR_STATUS) ? cpu_control_status
        : (dp_addr == ADDR_CTRL) ? general_irq_control
        : (dp_addr == ADDR_FLAGS) ? flag_view
        : (dp_addr == ADDR_PSW) ? processor_status_word
        : 8'h00;

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            dp_addr <= 8'h00;
            hreadyout_out <= 1'b1;
            hrdata_out <= 32'h0000_0000;
            hresp_out <= 1'b0;
        end
        else if (!hreadyout_out)
        begin
            // Read wait state: data is taken after any write just before it
            hrdata_out <= {24'h00_0000, rd_byte};
            hreadyout_out <= 1'b1;
            dp_rd <= 1'b0;
        end
        else
        begin
            dp_wr <= ahb_go & hwrite_in;
            dp_rd <= ahb_go & ~hwrite_in;
            hreadyout_out <= ~(ahb_go & ~hwrite_in);
            if (ahb_go)
            begin
                dp_addr <= {haddr_in[7:2], 2'b00};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            cpu_control_sense <= RESET_VALUE;
            cpu_control_status <= RESET_VALUE;
            general_irq_control <= RESET_VALUE;
            processor_status_word <= RESET_VALUE;
            sense_c_q <= 1'b0;
        end
        else
        begin
            if (wr_sense)
            begin
                cpu_control_sense <= wdat & MASK_SENSE;
            end
            if (wr_status)
            begin
                cpu_control_status <= wdat & MASK_STATUS;
            end
            if (wr_ctrl)
            begin
                general_irq_control <= wdat & MASK_CTRL;
            end
            if (wr_psw)
            begin
                processor_status_word <= wdat & MASK_PSW;
            end
            sense_c_q <= sense_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags: a new event wins over a clear in the same cycle

    wire [2:0] flag_set = {c_hit, edge_hit & ~is_level};
    wire [2:0] w1c = wr_flags ? {wdat[FLAG_C], wdat[FLAG_B], wdat[FLAG_A]} : 3'b000;
    wire [2:0] flag_clr = irq_ack_in | w1c;
    wire [2:0] flag_keep = {1'b1, ~is_level};

    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_flag
            assign next_flag[gi] = ((flag[gi] & ~flag_clr[gi]) | flag_set[gi])
                & flag_keep[gi]; // R17 R18
        end
    endgenerate

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            flag <= 3'b000;
        end
        else
        begin
            flag <= next_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Requests and wake

    wire [2:0] req_src = flag | {1'b0, level_req};
    wire c_wake = c_hit & pin_en[2] & power_down_in;

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            irq_req_out <= 3'b000;
            wake_out <= 1'b0;
        end
        else
        begin
            irq_req_out <= req_src & pin_en & {3{gie}}; // R12
            wake_out <= (|wake_ab) | c_wake; // R05
        end
    end

endmodule : eisn_top

// File: verification/eisn_asserts.sv
// Concurrent checks on the ports of the pin interrupt sense block
module eisn_asserts
    import eisn_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_DEFAULT
)
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic ext_irq_pin_a_in,
    input wire logic io_clk_run_in,
    input wire logic power_down_in,
    input wire logic [2:0] irq_req_out,
    input wire logic wake_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the enables and sense bits, since they are not visible at the ports
    logic take, wr_ph, lvl_a, fall_a;
    logic [7:0] wa, sense, ctrl, psw;
    logic [2:0] allow;
    assign take = hsel_in && htrans_in[1] && hready_in;
    assign allow = {ctrl[EN_C], ctrl[EN_B], ctrl[EN_A]} & {3{psw[PSW_GIE]}};
    assign lvl_a = sense[1:0] == EISN_LOW && allow[0] && !power_down_in;
    assign fall_a = sense[1:0] == EISN_FALL && allow[0] && io_clk_run_in;
    always_ff @(posedge ref_clk_in)
    begin
        wr_ph <= rstn_in && take && hwrite_in;
        wa <= haddr_in[7:0];
        if (!rstn_in)
        begin
            sense <= RESET_VALUE;
            ctrl <= RESET_VALUE;
            psw <= RESET_VALUE;
        end
        else if (wr_ph && wa == ADDR_SENSE)
            sense <= hwdata_in[7:0] & MASK_SENSE;
        else if (wr_ph && wa == ADDR_CTRL)
            ctrl <= hwdata_in[7:0] & MASK_CTRL;
        else if (wr_ph && wa == ADDR_PSW)
            psw <= hwdata_in[7:0] & MASK_PSW;
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_resp_okay: assert property (hresp_out == 1'b0)
        else $error("bus response not okay");
    a_read_wait: assert property (take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take && hwrite_in |=> hreadyout_out)
        else $error("write data phase stalled");
    a_rdata_hold: assert property ($changed(hrdata_out) |-> !$past(hreadyout_out))
        else $error("read data moved outside a read");
    a_req_gate: assert property ((irq_req_out & ~(allow | $past(allow))) == 3'b000)
        else $error("request without both enables");
    a_level_req: assert property ((!ext_irq_pin_a_in && lvl_a) [*8] |-> irq_req_out[0])
        else $error("level request missing while pin low");
    a_edge_req: assert property ($fell(ext_irq_pin_a_in)
        ##0 (fall_a && !ext_irq_pin_a_in) [*3] |-> ##[1:4] irq_req_out[0])
        else $error("falling edge not requested");
    a_wake_pulse: assert property (wake_out |=> !wake_out)
        else $error("wake longer than one cycle");
    a_wake_pd: assert property (wake_out |-> power_down_in || $past(power_down_in))
        else $error("wake outside power-down");
    c_wake: cover property ($rose(wake_out));
    c_req_c: cover property ($rose(irq_req_out[2]));
    c_level: cover property (lvl_a && irq_req_out[0]);
endmodule : eisn_asserts

// File: verification/eisn_pin_model.sv
// Model of the external sources that drive the three interrupt pins
module eisn_pin_model
(
    input wire logic ref_clk_in,
    output logic [2:0] pin_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pins idle high, as with pull-ups on interrupt inputs
    initial pin_out = 3'b111;
    // Source holds its level n cycles so the sampled value lands
    task drive(input int i, input logic v, input int n);
        @(posedge ref_clk_in);
        pin_out[i] <= v;
        repeat (n) @(posedge ref_clk_in);
    endtask : drive
    // Low pulse, kept wider than one clock and than the minimum width
    task pulse(input int i, input int n);
        drive(i, 1'b0, n);
        drive(i, 1'b1, 1);
    endtask : pulse
endmodule : eisn_pin_model

// File: verification/external_pin_interrupt_sense_tb.sv
// Self-checking bench for the external pin interrupt sense block
module external_pin_interrupt_sense_tb
    import eisn_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CEIL = 10000;
    logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ioclk = 1'b1, pd = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [2:0] ack = 3'b000, pins, req;
    logic hrdy, hresp, wake;
    int err_total = 0, tests_run = 0, cyc = 0, wakes = 0;
    always #4 clk = ~clk;
    eisn_pin_model PIN (.ref_clk_in(clk), .pin_out(pins));
    eisn_top #(.STARTUP_CYCLES(8)) DUT (.ref_clk_in(clk), .rstn_in(rstn), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
        .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
        .hresp_out(hresp), .ext_irq_pin_a_in(pins[0]), .ext_irq_pin_b_in(pins[1]),
        .ext_irq_pin_c_in(pins[2]), .io_clk_run_in(ioclk), .power_down_in(pd),
        .irq_ack_in(ack), .irq_req_out(req), .wake_out(wake));
    ////////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (wake === 1'b1)
            wakes <= wakes + 1;
        if (cyc == CEIL)
        begin
            err_total++;
            end_of_test;
        end
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Ready is looked at before the edge, so the edge that takes it is known
    task wait_rdy(output logic [31:0] rd);
        logic ok;
        ok = 1'b0;
        while (!ok)
        begin
            @(negedge clk);
            ok = hrdy === 1'b1;
            rd = hrdata;
            @(posedge clk);
        end
    endtask : wait_rdy
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy(rd);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy(rd);
    endtask : xfer
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        xfer(1'b1, a, {24'h0, d}, rd);
    endtask : wr
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] rd;
        xfer(1'b0, a, 32'h0, rd);
        check(rd, {24'h0, e});
    endtask : rd_chk
    task req_chk(input int i, input logic v, input int n);
        @(negedge clk);
        for (int k = 0; k < n && req[i] !== v; k++)
            @(negedge clk);
        check({31'h0, req[i]}, {31'h0, v});
    endtask : req_chk
    ////////////////////////////////////////////////////////////////////////////////
    // Flags first: a sense change on pin c may set its flag spuriously
    task t_regs;
        static logic [7:0] adr [6] = '{ADDR_FLAGS, ADDR_SENSE, ADDR_CTRL, ADDR_PSW,
            ADDR_STATUS, 8'h14};
        static logic [7:0] msk [6] = '{8'h00, MASK_SENSE, MASK_CTRL, MASK_PSW, MASK_STATUS,
            8'h00};
        for (int i = 0; i < 6; i++)
        begin
            rd_chk(adr[i], RESET_VALUE);
            wr(adr[i], 8'hff);
            rd_chk(adr[i], msk[i]);
            wr(adr[i], 8'h00);
        end
        wr(ADDR_FLAGS, 8'hff);
    endtask : t_regs
    task t_edges;
        eisn_sense_e m;
        wr(ADDR_CTRL, 8'hc0);
        wr(ADDR_PSW, 8'h80);
        for (int i = 1; i < 4; i++)
        begin
            m = eisn_sense_e'(i);
            wr(ADDR_SENSE, {4'h0, m, m});
            PIN.drive(0, 1'b0, 0);
            PIN.drive(1, 1'b0, 10);
            rd_chk(ADDR_FLAGS, (m != EISN_RISE) ? 8'hc0 : 8'h00);
            wr(ADDR_FLAGS, 8'hc0);
            rd_chk(ADDR_FLAGS, 8'h00);
            PIN.drive(0, 1'b1, 0);
            PIN.drive(1, 1'b1, 10);
            rd_chk(ADDR_FLAGS, (m != EISN_FALL) ? 8'hc0 : 8'h00);
            // Routine-executed pulses clear the pin a and b flags
            @(posedge clk);
            ack <= 3'b011;
            @(posedge clk);
            ack <= 3'b000;
            rd_chk(ADDR_FLAGS, 8'h00);
        end
    endtask : t_edges
    task t_level;
        wr(ADDR_SENSE, 8'h00);
        wr(ADDR_CTRL, 8'h40);
        PIN.drive(0, 1'b0, 0);
        req_chk(0, 1'b1, 20);
        rd_chk(ADDR_FLAGS, 8'h00);
        wr(ADDR_PSW, 8'h00);
        req_chk(0, 1'b0, 6);
        wr(ADDR_PSW, 8'h80);
        req_chk(0, 1'b1, 6);
        PIN.drive(0, 1'b1, 0);
        req_chk(0, 1'b0, 10);
    endtask : t_level
    // I/O clock stopped: pin a edges ignored, pin c still caught
    task t_pin_c;
        wr(ADDR_SENSE, {4'h0, EISN_FALL, EISN_FALL});
        wr(ADDR_CTRL, 8'he0);
        @(posedge clk);
        ioclk <= 1'b0;
        PIN.pulse(0, 4);
        PIN.pulse(2, 7);
        req_chk(2, 1'b1, 10);
        rd_chk(ADDR_FLAGS, 8'h20);
        @(posedge clk);
        ack <= 3'b100;
        @(posedge clk);
        ack <= 3'b000;
        req_chk(2, 1'b0, 6);
        wr(ADDR_CTRL, 8'hc0);
        wr(ADDR_STATUS, 8'h40);
        wr(ADDR_FLAGS, 8'h20);
        wr(ADDR_CTRL, 8'he0);
        rd_chk(ADDR_FLAGS, 8'h00);
        PIN.drive(2, 1'b0, 8);
        rd_chk(ADDR_FLAGS, 8'h00);
        PIN.drive(2, 1'b1, 8);
        rd_chk(ADDR_FLAGS, 8'h20);
        wr(ADDR_FLAGS, 8'h20);
        @(posedge clk);
        ioclk <= 1'b1;
    endtask : t_pin_c
    // Low held under one 1 us tick must not wake; a longer one must
    task t_wake;
        logic hit;
        hit = 1'b0;
        wr(ADDR_SENSE, 8'h00);
        wr(ADDR_CTRL, 8'h40);
        @(posedge clk);
        pd <= 1'b1;
        PIN.pulse(0, 100);
        repeat (300) @(negedge clk);
        check(32'(wakes), 32'h0);
        PIN.drive(0, 1'b0, 0);
        for (int k = 0; k < 500 && wake !== 1'b1; k++)
            @(negedge clk);
        check({31'h0, wake}, 32'h1);
        // Leave power-down while the pin is still low; it rises inside start-up
        @(posedge clk);
        pd <= 1'b0;
        PIN.drive(0, 1'b1, 0);
        repeat (30)
        begin
            @(negedge clk);
            hit = hit | req[0];
        end
        check({31'h0, hit}, 32'h0);
        check(32'(wakes), 32'h1);
    endtask : t_wake
    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_edges;
        t_level;
        t_pin_c;
        t_wake;
        end_of_test;
    end
endmodule : external_pin_interrupt_sense_tb
bind eisn_top eisn_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES)) CHK (.ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .ext_irq_pin_a_in(ext_irq_pin_a_in), .io_clk_run_in(io_clk_run_in),
    .power_down_in(power_down_in), .irq_req_out(irq_req_out), .wake_out(wake_out));
